// ---- logic/pbs_defines.svh ----
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define PBS_ADDR_W       16
`define PBS_DATA_W       32
`define PBS_LANES        4
`define PBS_WORDS        65536

// ----------------------------------------------------------------
// Burst counter
// ----------------------------------------------------------------
`define PBS_CNT_W        2
`define PBS_CNT_RESET    2'h0

// ----------------------------------------------------------------
// Write buffer and reset values
// ----------------------------------------------------------------
`define PBS_FIFO_DEPTH   8
`define PBS_DOUT_RESET   32'h0000_0000
`define PBS_MODE_RESET   1'h1

`endif

// ---- logic/pbs_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none

module pbs_fifo #(
    parameter int WIDTH = 52,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic     sys_clk_in,
    input  wire logic     rst_in,
    // Both sides of the buffer
    pbs_fifo_if.store     port
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] store_mem [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic             push_fire;
    logic             pop_fire;

    assign port.push_ready = (count_q != FULL_CNT);
    assign port.pop_valid  = (count_q != '0);
    assign port.pop_data   = store_mem[rd_ptr_q];
    assign push_fire       = port.push_valid && port.push_ready;
    assign pop_fire        = port.pop_valid && port.pop_ready;

    // ----------------------------------------------------------------
    // Storage, no reset needed
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        if (push_fire)
        begin
            store_mem[wr_ptr_q] <= port.push_data;
        end
    end

    // ----------------------------------------------------------------
    // Pointers and fill level
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (push_fire)
            begin
                wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop_fire)
            begin
                rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push_fire && !pop_fire)
            begin
                count_q <= count_q + 1'b1;
            end
            else if (pop_fire && !push_fire)
            begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule : pbs_fifo

`default_nettype wire

// ---- logic/pbs_fifo_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface pbs_fifo_if #(
    parameter int WIDTH = 52
);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport store (
        input  push_valid,
        input  push_data,
        input  pop_ready,
        output push_ready,
        output pop_valid,
        output pop_data
    );

    modport user (
        output push_valid,
        output push_data,
        output pop_ready,
        input  push_ready,
        input  pop_valid,
        input  pop_data
    );
endinterface : pbs_fifo_if

`default_nettype wire

// ---- logic/pbs_pkg.sv ----
`default_nettype none
`include "pbs_defines.svh"

package pbs_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic
    {
        PBS_DESELECTED,
        PBS_ACTIVE
    } pbs_state_t;

    typedef enum logic
    {
        PBS_ORDER_LINEAR,
        PBS_ORDER_INTERLEAVED
    } pbs_order_t;

    typedef struct packed
    {
        logic [`PBS_ADDR_W-1:0] addr;
        logic [`PBS_DATA_W-1:0] data;
        logic [`PBS_LANES-1:0]  lanes;
    } pbs_wr_entry_t;

endpackage : pbs_pkg

`default_nettype wire

// ---- logic/pbs_sram.sv ----
// Function
// - Register every synchronous input on rising edge
// - Read data leaves through an output register
// - 64K words of 32 bits, shared data bus
// - Interleaved or linear burst order selectable
// - Either address strobe starts an access
// - Start address seeds 2-bit wrapping burst counter
// - Burst steps only under burst_advance control
// - burst_advance low increments the burst counter
// - Address captured only on selected strobe
// - Byte selects write lanes when gate asserted
// - Byte selects ignored without byte_write_gate low
// - global_write low writes all four lanes
// - Writes complete by internal self-timed logic
// - Selected only with all three selects active
// - chip_sel_low_a high blocks processor strobe
// - Mask output enable on first read after deselect
// - Both strobes together: processor strobe wins
// - Order pin low linear, high interleaved
// - Output enable high releases the data lines
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.svh"

module pbs_sram #(
    parameter int ADDR_W     = `PBS_ADDR_W,
    parameter int DATA_W     = `PBS_DATA_W,
    parameter int WORDS      = `PBS_WORDS,
    parameter int FIFO_DEPTH = `PBS_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rst_in,
    // Address and access control
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic              processor_addr_strobe_n_in,
    input  wire logic              controller_addr_strobe_n_in,
    input  wire logic              burst_advance_n_in,
    input  wire logic              burst_order_select_in,
    // Write qualifiers
    input  wire logic [3:0]        byte_write_select_n_in,
    input  wire logic              byte_write_gate_n_in,
    input  wire logic              global_write_n_in,
    // Chip selects and output enable
    input  wire logic              chip_sel_low_a_n_in,
    input  wire logic              chip_sel_high_in,
    input  wire logic              chip_sel_low_b_n_in,
    input  wire logic              output_drive_enable_n_in,
    // Data lines, split into input, output and enable
    input  wire logic [DATA_W-1:0] dq_in,
    output var  logic [DATA_W-1:0] dq_out,
    output var  logic              dq_oe_out,
    // Status
    output var  logic              write_ready_out,
    output var  logic              burst_active_out,
    output var  logic [1:0]        burst_count_out
);

    localparam int LANES   = DATA_W / 8;
    localparam int ENTRY_W = $bits(pbs_pkg::pbs_wr_entry_t);

    // ----------------------------------------------------------------
    // Input registers
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] addr_q;
    logic              pstb_n_q;
    logic              cstb_n_q;
    logic              adv_n_q;
    logic [3:0]        bws_n_q;
    logic              bwg_n_q;
    logic              gw_n_q;
    logic              cs_a_n_q;
    logic              cs_h_q;
    logic              cs_b_n_q;
    logic [DATA_W-1:0] din_q;

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            addr_q   <= '0;
            pstb_n_q <= 1'b1;
            cstb_n_q <= 1'b1;
            adv_n_q  <= 1'b1;
            bws_n_q  <= 4'hF;
            bwg_n_q  <= 1'b1;
            gw_n_q   <= 1'b1;
            cs_a_n_q <= 1'b1;
            cs_h_q   <= 1'b0;
            cs_b_n_q <= 1'b1;
            din_q    <= '0;
        end
        else
        begin
            addr_q   <= addr_in;
            pstb_n_q <= processor_addr_strobe_n_in;
            cstb_n_q <= controller_addr_strobe_n_in;
            adv_n_q  <= burst_advance_n_in;
            bws_n_q  <= byte_write_select_n_in;
            bwg_n_q  <= byte_write_gate_n_in;
            gw_n_q   <= global_write_n_in;
            cs_a_n_q <= chip_sel_low_a_n_in;
            cs_h_q   <= chip_sel_high_in;
            cs_b_n_q <= chip_sel_low_b_n_in;
            din_q    <= dq_in;
        end
    end

    // ----------------------------------------------------------------
    // Asynchronous pins: two-stage synchronisers
    // ----------------------------------------------------------------
    // Output enable is not clocked by the far side, so it is resampled
    // here; this costs two cycles of enable latency against a glitch-free
    // drive control.
    logic oe_meta_n_q;
    logic oe_sync_n_q;
    logic mode_meta_q;
    logic mode_sync_q;

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            oe_meta_n_q <= 1'b1;
            oe_sync_n_q <= 1'b1;
            mode_meta_q <= `PBS_MODE_RESET;
            mode_sync_q <= `PBS_MODE_RESET;
        end
        else
        begin
            oe_meta_n_q <= output_drive_enable_n_in;
            oe_sync_n_q <= oe_meta_n_q;
            mode_meta_q <= burst_order_select_in;
            mode_sync_q <= mode_meta_q;
        end
    end

    pbs_pkg::pbs_order_t order;

    // Strap is expected static, so a plain level decode is enough
    assign order = mode_sync_q ? pbs_pkg::PBS_ORDER_INTERLEAVED
                               : pbs_pkg::PBS_ORDER_LINEAR;

    // ----------------------------------------------------------------
    // Strobe and select decode
    // ----------------------------------------------------------------
    logic selected;
    logic p_take;
    logic c_take;
    logic strobe;
    logic start;
    logic desel;

    pbs_pkg::pbs_state_t state_q;

    assign selected = !cs_a_n_q && cs_h_q && !cs_b_n_q;
    assign p_take   = !pstb_n_q && !cs_a_n_q;
    assign c_take   = !cstb_n_q && !p_take;
    assign strobe   = p_take || c_take;
    assign start    = strobe && selected;
    assign desel    = strobe && !selected;

    // ----------------------------------------------------------------
    // Burst counter and address generation
    // ----------------------------------------------------------------
    logic [ADDR_W-1:2]           base_q;
    logic [1:0]                  seed_q;
    logic [`PBS_CNT_W-1:0]       cnt_q;
    logic [`PBS_CNT_W-1:0]       cnt_d;
    logic [ADDR_W-1:2]           base_now;
    logic [1:0]                  seed_now;
    logic [1:0]                  offset;
    logic                        cont;
    logic                        step;
    logic                        access;
    logic [ADDR_W-1:0]           acc_addr;

    assign cont     = !strobe && (state_q == pbs_pkg::PBS_ACTIVE);
    assign step     = cont && !adv_n_q;
    assign access   = start || cont;
    assign base_now = start ? addr_q[ADDR_W-1:2] : base_q;
    assign seed_now = start ? addr_q[1:0] : seed_q;

    always_comb
    begin
        if (start)
        begin
            cnt_d = `PBS_CNT_RESET;
        end
        else if (step)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else
        begin
            cnt_d = cnt_q;
        end
    end

    always_comb
    begin
        if (order == pbs_pkg::PBS_ORDER_INTERLEAVED)
        begin
            offset = seed_now ^ cnt_d;
        end
        else
        begin
            offset = seed_now + cnt_d;
        end
    end

    assign acc_addr = {base_now, offset};

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            base_q <= '0;
            seed_q <= '0;
            cnt_q  <= `PBS_CNT_RESET;
        end
        else
        begin
            base_q <= base_now;
            seed_q <= seed_now;
            cnt_q  <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Access state
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= pbs_pkg::PBS_DESELECTED;
        end
        else
        begin
            unique case (state_q)
                pbs_pkg::PBS_DESELECTED:
                begin
                    if (start)
                    begin
                        state_q <= pbs_pkg::PBS_ACTIVE;
                    end
                end
                pbs_pkg::PBS_ACTIVE:
                begin
                    if (desel)
                    begin
                        state_q <= pbs_pkg::PBS_DESELECTED;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Write qualification
    // ----------------------------------------------------------------
    // A processor-strobe start is always a read; the write qualifiers
    // count only on controller starts and on burst continuations.
    logic [LANES-1:0] lanes;
    logic             is_write;
    logic             is_read;
    logic             oe_mask;

    always_comb
    begin
        if (!gw_n_q)
        begin
            lanes = '1;
        end
        else if (!bwg_n_q)
        begin
            lanes = ~bws_n_q;
        end
        else
        begin
            lanes = '0;
        end
    end

    assign is_write = access && !(start && p_take) && (lanes != '0);
    assign is_read  = access && !is_write;
    assign oe_mask  = start && (state_q == pbs_pkg::PBS_DESELECTED);

    // ----------------------------------------------------------------
    // Write buffer
    // ----------------------------------------------------------------
    // Writes queue here and drain into the array on cycles with no
    // read, so a run of reads stalls the drain and holds the queued writes in the buffer.
    // Limitation: a read does not snoop queued writes.
    pbs_fifo_if #(.WIDTH(ENTRY_W)) wr_fifo_if ();

    pbs_pkg::pbs_wr_entry_t push_entry;
    pbs_pkg::pbs_wr_entry_t pop_entry;

    assign push_entry.addr    = acc_addr;
    assign push_entry.data    = din_q;
    assign push_entry.lanes   = lanes;
    assign wr_fifo_if.push_valid = is_write;
    assign wr_fifo_if.push_data  = push_entry;
    assign wr_fifo_if.pop_ready  = !is_read;
    assign pop_entry             = wr_fifo_if.pop_data;

    pbs_fifo #(
        .WIDTH (ENTRY_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .port       (wr_fifo_if.store)
    );

    // ----------------------------------------------------------------
    // Memory array, single port
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:WORDS-1];
    logic              drain;

    assign drain = wr_fifo_if.pop_valid && !is_read;

    always_ff @(posedge sys_clk_in)
    begin
        if (drain)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (pop_entry.lanes[i])
                begin
                    mem[pop_entry.addr][i*8 +: 8] <= pop_entry.data[i*8 +: 8];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Output register and drive control
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            dq_out <= `PBS_DOUT_RESET;
        end
        else if (is_read)
        begin
            dq_out <= mem[acc_addr];
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            dq_oe_out <= 1'b0;
        end
        else
        begin
            dq_oe_out <= is_read && !oe_sync_n_q && !oe_mask;
        end
    end

    // ----------------------------------------------------------------
    // Status
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            write_ready_out  <= 1'b0;
            burst_active_out <= 1'b0;
            burst_count_out  <= `PBS_CNT_RESET;
        end
        else
        begin
            write_ready_out  <= wr_fifo_if.push_ready;
            burst_active_out <= access;
            burst_count_out  <= cnt_d;
        end
    end

endmodule : pbs_sram

`default_nettype wire

// ---- test/pbs_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module pbs_host_model (
    // Clock
    input  wire logic        sys_clk_in,
    // Data lines from the device
    input  wire logic [31:0] dq_dev_in,
    input  wire logic        dq_oe_in,
    // Pins towards the device
    output var  logic [15:0] addr_out,
    output var  logic [1:0]  strobe_n_out,
    output var  logic        adv_n_out,
    output var  logic [2:0]  sel_out,
    output var  logic [5:0]  wq_n_out,
    output wire logic [31:0] dq_bus_out
);
    logic [31:0] wdata_q;
    logic        drive_q;
    logic [31:0] last_q;

    initial
    begin
        addr_out     = 16'h0000;
        strobe_n_out = 2'b11;
        adv_n_out    = 1'b1;
        sel_out      = 3'b000;
        wq_n_out     = 6'h3F;
        wdata_q      = 32'h0000_0000;
        drive_q      = 1'b0;
        last_q       = 32'h0000_0000;
    end

    // ----
    // Shared data lines
    // ----
    // Undriven lines must not look like held data, so they show the inverse of the last value
    assign dq_bus_out = drive_q ? wdata_q : (dq_oe_in ? dq_dev_in : ~last_q);

    always @(posedge sys_clk_in)
        last_q <= dq_bus_out;

    // One bus cycle, launched at the falling edge; {ps_n, cs_n}, {sel_a_n, sel_h, sel_b_n}, {bw_n, gate_n, gw_n}
    task automatic beat(input logic [15:0] a, input logic [1:0] s_n, input logic adv_n, input logic [2:0] sel,
                        input logic [5:0] wq_n, input logic [31:0] d);
        @(negedge sys_clk_in);
        addr_out     = a;
        strobe_n_out = s_n;
        adv_n_out    = adv_n;
        sel_out      = sel;
        wq_n_out     = wq_n;
        wdata_q      = d;
        drive_q      = !wq_n[0] || !wq_n[1];
    endtask : beat
endmodule : pbs_host_model

`default_nettype wire

// ---- test/pbs_sram_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

module pbs_sram_properties (
    // Clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    // Watched pins
    input  wire logic       processor_addr_strobe_n_in,
    input  wire logic       controller_addr_strobe_n_in,
    input  wire logic       burst_advance_n_in,
    input  wire logic       byte_write_gate_n_in,
    input  wire logic       global_write_n_in,
    input  wire logic       chip_sel_low_a_n_in,
    input  wire logic       chip_sel_high_in,
    input  wire logic       chip_sel_low_b_n_in,
    input  wire logic       output_drive_enable_n_in,
    input  wire logic       dq_oe_out,
    input  wire logic       burst_active_out,
    input  wire logic [1:0] burst_count_out
);
    logic sel_ok;
    logic start_c;
    logic idle_c;
    logic rd_c;
    logic desel_c;
    logic oe_c;

    assign sel_ok  = !chip_sel_low_a_n_in && chip_sel_high_in && !chip_sel_low_b_n_in;
    assign idle_c  = processor_addr_strobe_n_in && controller_addr_strobe_n_in;
    assign start_c = sel_ok && !idle_c;
    assign rd_c    = global_write_n_in && byte_write_gate_n_in;
    assign desel_c = !controller_addr_strobe_n_in && !chip_sel_high_in;
    assign oe_c    = !output_drive_enable_n_in;

    // Shadow of the device's select state; only the plain deselect is tracked,
    // so a missed deselect can only silence a check, never fire one falsely
    logic desel_q;

    always_ff @(posedge sys_clk_in or posedge rst_in)
        if (rst_in)
            desel_q <= 1'b1;
        else if (desel_c || start_c)
            desel_q <= desel_c;

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    a_desel_quiet: assert property (desel_c |-> ##2 !burst_active_out && !dq_oe_out)
        else $error("deselect left the device active");
    a_start_seed: assert property (start_c |-> ##2 burst_active_out && burst_count_out == 2'h0)
        else $error("start did not seed the count");
    a_adv_step: assert property (start_c ##1 (idle_c && !burst_advance_n_in) |-> ##2 burst_count_out == 2'h1)
        else $error("advance did not step the count");
    a_adv_hold: assert property (start_c ##1 (idle_c && burst_advance_n_in) |-> ##2 burst_count_out == 2'h0)
        else $error("count moved without advance");
    a_proc_gated: assert property (desel_q && !processor_addr_strobe_n_in && chip_sel_low_a_n_in
        && controller_addr_strobe_n_in |-> ##2 !burst_active_out)
        else $error("gated processor strobe started an access");
    a_first_mask: assert property (desel_q && start_c && rd_c |-> ##2 !dq_oe_out)
        else $error("first read after deselect drove the bus");
    a_oe_release: assert property (output_drive_enable_n_in [*5] |-> !dq_oe_out)
        else $error("bus driven while output enable high");
    a_oe_access: assert property (dq_oe_out |-> burst_active_out)
        else $error("bus driven outside an access");
    a_cont_drive: assert property (oe_c [*4] ##1 (start_c && rd_c && oe_c) ##1 (idle_c && rd_c && oe_c)
        |-> ##2 dq_oe_out)
        else $error("burst read did not drive the bus");

    c_read: cover property (start_c && rd_c);
    c_write: cover property (start_c && !global_write_n_in);
    c_desel: cover property (desel_c);
endmodule : pbs_sram_properties

bind pbs_sram pbs_sram_properties i_props (
    .sys_clk_in, .rst_in, .processor_addr_strobe_n_in, .controller_addr_strobe_n_in, .burst_advance_n_in,
    .byte_write_gate_n_in, .global_write_n_in, .chip_sel_low_a_n_in, .chip_sel_high_in, .chip_sel_low_b_n_in,
    .output_drive_enable_n_in, .dq_oe_out, .burst_active_out, .burst_count_out
);

`default_nettype wire

// ---- test/pbs_sram_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module pbs_sram_tb;
    logic        sys_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        burst_order_select_in = 1'b1;
    logic        output_drive_enable_n_in = 1'b0;
    logic [15:0] addr;
    logic [1:0]  strb_n;
    logic        adv_n;
    logic [2:0]  sel;
    logic [5:0]  wq_n;
    logic [31:0] dq_bus;
    logic [31:0] dq_out;
    logic        dq_oe_out;
    logic        write_ready_out;
    logic        burst_active_out;
    int          failures = 0;
    int          total_checks = 0;
    logic [31:0] exp_mem [logic [15:0]];

    always #20 sys_clk_in = ~sys_clk_in;

    pbs_host_model i_host (
        .sys_clk_in(sys_clk_in), .dq_dev_in(dq_out), .dq_oe_in(dq_oe_out), .addr_out(addr),
        .strobe_n_out(strb_n), .adv_n_out(adv_n), .sel_out(sel), .wq_n_out(wq_n), .dq_bus_out(dq_bus)
    );

    pbs_sram i_dut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr), .processor_addr_strobe_n_in(strb_n[1]),
        .controller_addr_strobe_n_in(strb_n[0]), .burst_advance_n_in(adv_n),
        .burst_order_select_in(burst_order_select_in), .byte_write_select_n_in(wq_n[5:2]),
        .byte_write_gate_n_in(wq_n[1]), .global_write_n_in(wq_n[0]), .chip_sel_low_a_n_in(sel[2]),
        .chip_sel_high_in(sel[1]), .chip_sel_low_b_n_in(sel[0]),
        .output_drive_enable_n_in(output_drive_enable_n_in), .dq_in(dq_bus), .dq_out(dq_out),
        .dq_oe_out(dq_oe_out), .write_ready_out(write_ready_out), .burst_active_out(burst_active_out),
        .burst_count_out()
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    function automatic logic [15:0] baddr(input logic [15:0] a, input int k, input logic ilv);
        logic [1:0] c;
        c = ilv ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
        return {a[15:2], c};
    endfunction : baddr

    task automatic wr(input logic [15:0] a, input logic [1:0] s_n, input logic [5:0] q, input logic [31:0] d);
        logic [31:0] m;
        i_host.beat(a, s_n, 1'b1, 3'b010, q, d);
        m = !q[0] ? 32'hFFFF_FFFF : {{8{!q[5]}}, {8{!q[4]}}, {8{!q[3]}}, {8{!q[2]}}};
        if (s_n[1] && (!q[0] || !q[1]))
            exp_mem[a] = ((exp_mem.exists(a) ? exp_mem[a] : 32'h0000_0000) & ~m) | (d & m);
    endtask : wr

    // Deselect, then idle long enough for queued writes and the synchronisers to settle
    task automatic t_deselect();
        i_host.beat(16'h0000, 2'b10, 1'b1, 3'b000, 6'h3F, 32'h0000_0000);
        repeat (4) i_host.beat(16'h0000, 2'b11, 1'b1, 3'b000, 6'h3F, 32'h0000_0000);
        check(burst_active_out, 1'b0);
    endtask : t_deselect

    task automatic t_burst_write();
        for (int k = 0; k < 4; k++)
        begin
            i_host.beat(16'h0A41, k == 0 ? 2'b10 : 2'b11, k == 0, 3'b010, 6'b111110, 32'hC0DE_0000 | k);
            exp_mem[baddr(16'h0A41, k, 1'b1)] = 32'hC0DE_0000 | k;
        end
        check(burst_active_out, 1'b1);
    endtask : t_burst_write

    task automatic t_byte_write();
        wr(16'h0200, 2'b10, 6'b111110, 32'h1111_1111);
        wr(16'h0200, 2'b10, 6'b000011, 32'hFFFF_FFFF);
        wr(16'h0200, 2'b10, 6'b101001, 32'hAAAA_AAAA);
        wr(16'h0201, 2'b10, 6'b111000, 32'h2222_2222);
        wr(16'h0200, 2'b00, 6'b111110, 32'hDEAD_BEEF);
    endtask : t_byte_write

    task automatic t_gated();
        i_host.beat(16'h0A41, 2'b01, 1'b1, 3'b110, 6'h3F, 32'h0000_0000);
        repeat (2) i_host.beat(16'h0000, 2'b11, 1'b1, 3'b000, 6'h3F, 32'h0000_0000);
        check(burst_active_out, 1'b0);
    endtask : t_gated

    // Seven-beat read, the second beat holds the count; beats 0 to 4 are each judged two beats later
    task automatic rd_burst(input logic [15:0] a, input logic proc, input logic masked, input logic oe_on);
        logic [15:0] ea;
        for (int k = 0; k < 7; k++)
        begin
            i_host.beat(a, k > 0 ? 2'b11 : (proc ? 2'b01 : 2'b10), k < 2 || k > 4, 3'b010, 6'h3F, 32'h0000_0000);
            if (k >= 2)
            begin
                ea = baddr(a, k > 3 ? k - 3 : 0, burst_order_select_in);
                if (exp_mem.exists(ea))
                    check(dq_out, exp_mem[ea]);
                check(dq_oe_out, oe_on && !(masked && k == 2));
            end
        end
    endtask : rd_burst

    task automatic t_linear();
        @(negedge sys_clk_in);
        burst_order_select_in = 1'b0;
        t_deselect();
        rd_burst(16'h0A42, 1'b0, 1'b1, 1'b1);
    endtask : t_linear

    task automatic t_oe_off();
        @(negedge sys_clk_in);
        output_drive_enable_n_in = 1'b1;
        t_deselect();
        rd_burst(16'h0A40, 1'b1, 1'b1, 1'b0);
        @(negedge sys_clk_in);
        output_drive_enable_n_in = 1'b0;
    endtask : t_oe_off

    initial
    begin
        repeat (6) @(negedge sys_clk_in);
        rst_in = 1'b0;
        t_burst_write();
        t_byte_write();
        t_deselect();
        check(write_ready_out, 1'b1);
        t_gated();
        rd_burst(16'h0A41, 1'b0, 1'b1, 1'b1);
        rd_burst(16'h0200, 1'b1, 1'b0, 1'b1);
        t_linear();
        t_oe_off();
        results();
    end

    // Whole run needs about 64 cycles
    initial
    begin
        repeat (2000) @(posedge sys_clk_in);
        failures++;
        results();
    end
endmodule : pbs_sram_tb

`default_nettype wire
